// ---- shared/codec_map.svh ----
// Purpose: offsets, control bit positions, reset values and timing counts of the symbol codec
// Assumes: byte-wide register port, one register per offset
// Notes: data bytes are right justified; the high byte is unused in Manchester mode
//
// How it works
// RULE_01: three-of-six encode maps each nibble to one six-bit symbol, 24 bits total.
// RULE_02: three-of-six encode takes middle and low bytes with mode select 1, encode start.
// RULE_03: encode result replaces input in high, middle and low data registers.
// RULE_04: nibbles 0 to F map to the sixteen fixed six-bit symbols in table order.
// RULE_05: decode takes three symbol bytes, decode start, ready flag set on completion.
// RULE_06: decode returns the nibble each valid symbol stands for, inverse of encode map.
// RULE_07: any invalid six-bit pattern in a three-of-six decode sets the error flag.
// RULE_08: encode then decode gives back the original middle and low bytes.
// RULE_09: software clears control with 0x00 before loading the data registers.
// RULE_10: control write 0x10 starts Manchester decode, 0x11 three-of-six decode.
// RULE_11: control write 0x20 starts Manchester encode, 0x21 three-of-six encode.
// RULE_12: software polls ready, checks error after decodes, reads results, repeats.
// RULE_13: ready and error flags stay set until software clears them.
// RULE_14: a decode error raises the error interrupt request.
// RULE_15: in DMA operation a decode error does not halt the codec.
// RULE_16: error flag stays set across the whole DMA transfer once any block fails.
// RULE_17: abort handler stalls, disables, then clears the codec DMA channels.
// RULE_18: DMA control write 0x16 starts Manchester decode, 0x17 three-of-six decode.
// RULE_19: DMA control write 0x26 starts Manchester encode, 0x27 three-of-six encode.
// RULE_20: software sets up input channel code 0x00 and output channel code 0x01.
// RULE_21: codec and its DMA channels are set up for big-endian transfers.
// RULE_22: software enables DMA interrupt bit 5 and codec error interrupt bit 6.
// RULE_23: Manchester encode turns 0 into 10 and 1 into 01, upper nibble to middle.
// RULE_24: invalid Manchester decode input sets error and drives all result bytes to FF.
// RULE_25: start bits clear themselves once the operation begins; ready stays.
// RULE_26: mode select 0 picks Manchester, 1 picks three-of-six, for both directions.
// RULE_27: most significant nibble becomes the most significant six bits of the result.
// RULE_28: any invalid three-of-six symbol flags error and drives result bytes to FF.
// RULE_29: in DMA mode the codec requests input and output bytes and runs blocks itself.
`ifndef CODEC_MAP_SVH
`define CODEC_MAP_SVH
`define CODEC_OFS_LOW 8'h00
`define CODEC_OFS_MIDDLE 8'h01
`define CODEC_OFS_HIGH 8'h02
`define CODEC_OFS_CONTROL 8'h03
`define CODEC_BIT_READY 7
`define CODEC_BIT_ERROR 6
`define CODEC_BIT_ENCODE 5
`define CODEC_BIT_DECODE 4
`define CODEC_BIT_DMA 2
`define CODEC_BIT_ENDIAN 1
`define CODEC_BIT_MODE 0
`define CODEC_CONTROL_RESET 8'h00
`define CODEC_DATA_RESET 8'h00
`define CODEC_CONTROL_WMASK 8'h37
`define CODEC_ERROR_FILL 8'hff
`define CODEC_SYMBOL_VALID_BITS 6
`define CODEC_DMA_SPACING_CYCLES 1
`endif

// ---- shared/codec_pkg.sv ----
// Purpose: types shared by the codec files
// Assumes: nothing beyond the map header
// Notes: sequencer states are binary coded
package codec_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_calc = 3'b001,
    st_fetch = 3'b010,
    st_wait_in = 3'b011,
    st_emit = 3'b100,
    st_wait_out = 3'b101
  } codec_state_t;
  typedef logic [7:0] codec_byte_t;
endpackage : codec_pkg

// ---- hdl/codec_symbol_core.sv ----
// Purpose: combinational symbol translation for both coding modes
// Assumes: inputs stable while the caller samples the outputs
// Notes: on any decode error all three result bytes read as FF
`timescale 1ns/100ps
`include "codec_map.svh"
module codec_symbol_core (
  // operation
  input wire logic mode_sel,
  input wire logic do_decode,
  // data in
  input wire logic [7:0] in_high,
  input wire logic [7:0] in_middle,
  input wire logic [7:0] in_low,
  // data out
  output logic [7:0] out_high,
  output logic [7:0] out_middle,
  output logic [7:0] out_low,
  output logic bad_input
);
  function automatic logic [5:0] nib_to_sym(input logic [3:0] n);
    case (n)
      4'h0: nib_to_sym = 6'b010110; // RULE_04
      4'h1: nib_to_sym = 6'b001101;
      4'h2: nib_to_sym = 6'b001110;
      4'h3: nib_to_sym = 6'b001011;
      4'h4: nib_to_sym = 6'b011100;
      4'h5: nib_to_sym = 6'b011001;
      4'h6: nib_to_sym = 6'b011010;
      4'h7: nib_to_sym = 6'b010011;
      4'h8: nib_to_sym = 6'b101100;
      4'h9: nib_to_sym = 6'b100101;
      4'ha: nib_to_sym = 6'b100110;
      4'hb: nib_to_sym = 6'b100011;
      4'hc: nib_to_sym = 6'b110100;
      4'hd: nib_to_sym = 6'b110001;
      4'he: nib_to_sym = 6'b110010;
      default: nib_to_sym = 6'b101001;
    endcase
  endfunction : nib_to_sym

  // bit 4 is the invalid mark; searching the encode table keeps one source of truth
  function automatic logic [4:0] sym_to_nib(input logic [5:0] s);
    sym_to_nib = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (nib_to_sym(4'(i)) == s) begin
        sym_to_nib = {1'b0, 4'(i)}; // RULE_06
      end
    end
  endfunction : sym_to_nib

  function automatic logic [7:0] man_enc(input logic [3:0] n);
    man_enc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      man_enc[2*i +: 2] = n[i] ? 2'b01 : 2'b10; // RULE_23
    end
  endfunction : man_enc

  // bit 4 is the invalid mark
  function automatic logic [4:0] man_dec(input logic [7:0] b);
    man_dec = 5'h00;
    for (int i = 0; i < 4; i++) begin
      man_dec[i] = (b[2*i +: 2] == 2'b01);
      if (b[2*i +: 2] == 2'b00 || b[2*i +: 2] == 2'b11) begin
        man_dec[4] = 1'b1;
      end
    end
  endfunction : man_dec

  logic [23:0] sym_word;
  logic [4:0] dec_nib [4];
  logic [4:0] man_hi;
  logic [4:0] man_lo;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sym
      assign dec_nib[g] = sym_to_nib(sym_word[6*g +: 6]);
    end
  endgenerate
  assign sym_word = {in_high, in_middle, in_low};
  assign man_hi = man_dec(in_middle);
  assign man_lo = man_dec(in_low);

  always_comb begin
    out_high = 8'h00;
    out_middle = 8'h00;
    out_low = 8'h00;
    bad_input = 1'b0;
    if (!do_decode && mode_sel) begin
      // msb nibble lands in the top six bits
      {out_high, out_middle, out_low} = {nib_to_sym(in_middle[7:4]), nib_to_sym(in_middle[3:0]),
        nib_to_sym(in_low[7:4]), nib_to_sym(in_low[3:0])}; // RULE_01 RULE_27
    end else if (!do_decode) begin
      out_middle = man_enc(in_low[7:4]); // RULE_23
      out_low = man_enc(in_low[3:0]);
    end else if (mode_sel) begin
      bad_input = dec_nib[0][4] | dec_nib[1][4] | dec_nib[2][4] | dec_nib[3][4]; // RULE_07
      out_middle = {dec_nib[3][3:0], dec_nib[2][3:0]}; // RULE_08
      out_low = {dec_nib[1][3:0], dec_nib[0][3:0]};
    end else begin
      bad_input = man_hi[4] | man_lo[4];
      out_low = {man_hi[3:0], man_lo[3:0]};
    end
    if (bad_input) begin
      out_high = `CODEC_ERROR_FILL; // RULE_24 RULE_28
      out_middle = `CODEC_ERROR_FILL;
      out_low = `CODEC_ERROR_FILL;
    end
  end
endmodule : codec_symbol_core

// ---- hdl/symbol_codec.sv ----
// Purpose: register-mapped Manchester and three-of-six codec with a byte DMA port
// Assumes: one clock, synchronous active-low reset, byte-wide register port
// Notes: one block takes one cycle to compute; DMA streams block after block
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "codec_map.svh"
module symbol_codec (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // dma input channel: memory to codec
  output logic dma_in_req,
  input wire logic dma_in_ack,
  input wire logic [7:0] dma_in_data,
  // dma output channel: codec to memory
  output logic dma_out_req,
  input wire logic dma_out_ack,
  output logic [7:0] dma_out_data,
  // status
  output logic decode_err_irq,
  output logic ready_flag
);
  codec_pkg::codec_state_t state_r;
  logic [7:0] data_r [3];
  logic mode_r;
  logic dma_en_r;
  logic endian_r;
  logic is_decode_r;
  logic ready_r;
  logic error_r;
  logic [1:0] cnt_r;
  logic [7:0] res_high;
  logic [7:0] res_middle;
  logic [7:0] res_low;
  logic res_bad;
  logic ctl_wr;
  logic start_enc;
  logic start_dec;
  logic calc_done;

  // byte counts per block, depending on direction and mode
  function automatic logic [1:0] in_bytes(input logic dec, input logic m);
    in_bytes = dec ? (m ? 2'd3 : 2'd2) : (m ? 2'd2 : 2'd1);
  endfunction : in_bytes

  function automatic logic [1:0] out_bytes(input logic dec, input logic m);
    out_bytes = dec ? (m ? 2'd2 : 2'd1) : (m ? 2'd3 : 2'd2);
  endfunction : out_bytes

  assign ctl_wr = clk_en && reg_wr && (reg_addr == `CODEC_OFS_CONTROL);
  assign start_enc = ctl_wr && reg_wdata[`CODEC_BIT_ENCODE]; // RULE_11 RULE_19
  assign start_dec = ctl_wr && reg_wdata[`CODEC_BIT_DECODE] &&
    !reg_wdata[`CODEC_BIT_ENCODE]; // RULE_10 RULE_18
  assign calc_done = clk_en && (state_r == codec_pkg::st_calc);

  codec_symbol_core u_core (
    .mode_sel(mode_r),
    .do_decode(is_decode_r),
    .in_high(data_r[2]),
    .in_middle(data_r[1]),
    .in_low(data_r[0]),
    .out_high(res_high),
    .out_middle(res_middle),
    .out_low(res_low),
    .bad_input(res_bad)
  );

  // control bits steered by software
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_r <= 1'b0;
      dma_en_r <= 1'b0;
      endian_r <= 1'b0;
      is_decode_r <= 1'b0;
    end else if (ctl_wr) begin
      mode_r <= reg_wdata[`CODEC_BIT_MODE]; // RULE_26 RULE_02
      dma_en_r <= reg_wdata[`CODEC_BIT_DMA];
      endian_r <= reg_wdata[`CODEC_BIT_ENDIAN];
      if (start_enc || start_dec) begin
        is_decode_r <= start_dec;
      end
    end
  end

  // sequencer; start bits never stay stored, so they read back as zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_r <= codec_pkg::st_idle;
      cnt_r <= 2'd0;
    end else if (clk_en) begin
      case (state_r)
        codec_pkg::st_idle: begin
          if (start_enc || start_dec) begin
            cnt_r <= 2'd0;
            // RULE_25 RULE_29
            state_r <= reg_wdata[`CODEC_BIT_DMA] ? codec_pkg::st_fetch : codec_pkg::st_calc;
          end
        end
        codec_pkg::st_fetch: begin
          state_r <= codec_pkg::st_wait_in;
        end
        codec_pkg::st_wait_in: begin
          if (dma_in_ack) begin
            if (cnt_r == in_bytes(is_decode_r, mode_r) - 2'd1) begin
              cnt_r <= 2'd0;
              state_r <= codec_pkg::st_calc;
            end else begin
              cnt_r <= cnt_r + 2'd1;
            end
          end
        end
        codec_pkg::st_calc: begin
          state_r <= dma_en_r ? codec_pkg::st_emit : codec_pkg::st_idle;
        end
        codec_pkg::st_emit: begin
          state_r <= codec_pkg::st_wait_out;
        end
        codec_pkg::st_wait_out: begin
          if (dma_out_ack) begin
            if (cnt_r == out_bytes(is_decode_r, mode_r) - 2'd1) begin
              cnt_r <= 2'd0;
              // keep streaming until the channels are stopped by software
              state_r <= codec_pkg::st_fetch; // RULE_15 RULE_29
            end else begin
              cnt_r <= cnt_r + 2'd1;
            end
          end
        end
        default: begin
          state_r <= codec_pkg::st_idle;
        end
      endcase
      if (ctl_wr && !(start_enc || start_dec) && !reg_wdata[`CODEC_BIT_DMA]) begin
        state_r <= codec_pkg::st_idle;
      end
    end
  end

  // data registers: software writes, dma input bytes, results
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) begin
        data_r[i] <= `CODEC_DATA_RESET;
      end
    end else if (clk_en) begin
      if (calc_done) begin
        data_r[2] <= res_high; // RULE_03 RULE_05
        data_r[1] <= res_middle;
        data_r[0] <= res_low;
      end else if (state_r == codec_pkg::st_wait_in && dma_in_ack) begin
        // right-justified block: the first byte in goes highest when big-endian
        if (endian_r) begin
          data_r[0] <= dma_in_data;
          data_r[1] <= data_r[0];
          data_r[2] <= data_r[1];
        end else begin
          data_r[cnt_r] <= dma_in_data;
        end
      end else if (reg_wr && reg_addr < `CODEC_OFS_CONTROL) begin
        data_r[reg_addr[1:0]] <= reg_wdata; // RULE_02
      end
    end
  end

  // sticky flags; a completion in the same cycle as a clear wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ready_r <= 1'b0;
      error_r <= 1'b0;
    end else if (clk_en) begin
      if (ctl_wr) begin
        ready_r <= reg_wdata[`CODEC_BIT_READY] & ready_r; // RULE_13
        error_r <= reg_wdata[`CODEC_BIT_ERROR] & error_r;
      end
      if (calc_done) begin
        ready_r <= 1'b1; // RULE_05
      end
      if (calc_done && is_decode_r && res_bad) begin
        error_r <= 1'b1; // RULE_07 RULE_16
      end
    end
  end

  // read port: data one cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `CODEC_OFS_LOW: reg_rdata <= data_r[0];
          `CODEC_OFS_MIDDLE: reg_rdata <= data_r[1];
          `CODEC_OFS_HIGH: reg_rdata <= data_r[2];
          `CODEC_OFS_CONTROL: reg_rdata <= {ready_r, error_r, 3'b000, dma_en_r, endian_r, mode_r};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dma_in_req <= 1'b0;
      dma_out_req <= 1'b0;
      dma_out_data <= 8'h00;
      decode_err_irq <= 1'b0;
      ready_flag <= 1'b0;
    end else if (clk_en) begin
      dma_in_req <= (state_r == codec_pkg::st_fetch) ||
        (state_r == codec_pkg::st_wait_in && !(dma_in_ack &&
        cnt_r == in_bytes(is_decode_r, mode_r) - 2'd1)); // RULE_29
      dma_out_req <= (state_r == codec_pkg::st_emit) ||
        (state_r == codec_pkg::st_wait_out && !(dma_out_ack &&
        cnt_r == out_bytes(is_decode_r, mode_r) - 2'd1));
      if (state_r == codec_pkg::st_emit || (state_r == codec_pkg::st_wait_out && dma_out_ack)) begin
        // bytes leave most significant first of the right-justified result
        dma_out_data <= data_r[out_bytes(is_decode_r, mode_r) - 2'd1 -
          ((state_r == codec_pkg::st_emit) ? 2'd0 : cnt_r + 2'd1)];
      end
      decode_err_irq <= error_r; // RULE_14
      ready_flag <= ready_r;
    end
  end

  // ready flag holds until cleared by a control write
  ready_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_13
    $past(ready_r) && !$past(ctl_wr) |-> ready_r)
    else $error("ready flag dropped without a clear");

  // completion always raises ready on the next edge
  ready_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_05
    calc_done |=> ready_r)
    else $error("ready not set after block");

  // decode error latches
  error_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_07
    calc_done && is_decode_r && res_bad |=> error_r)
    else $error("decode error not flagged");

  // bad decode fills results with FF
  error_fill_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_28
    calc_done && is_decode_r && res_bad |=> data_r[0] == 8'hff && data_r[1] == 8'hff &&
    data_r[2] == 8'hff)
    else $error("bad decode not filled");

  // register start runs one calc cycle then returns idle
  start_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_25
    (start_enc || start_dec) && !reg_wdata[`CODEC_BIT_DMA] && state_r == codec_pkg::st_idle
    |=> state_r == codec_pkg::st_calc ##1 (!clk_en || state_r == codec_pkg::st_idle))
    else $error("start did not self clear");

  // error holds through a dma transfer
  error_dma_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_16
    error_r && dma_en_r && !ctl_wr |=> error_r)
    else $error("error lost in dma transfer");

  // decode error drives the interrupt line
  err_irq_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_14
    error_r && clk_en |=> decode_err_irq)
    else $error("error irq missing");

  // dma error does not stop streaming
  dma_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE_15
    calc_done && dma_en_r |=> state_r == codec_pkg::st_emit)
    else $error("dma halted after block");
endmodule : symbol_codec

// ---- bench/dma_mem_model.sv ----
// Purpose: memory side of the codec's two byte channels
// Assumes: requests are levels, acks are one-cycle pulses taken at the rising edge
// Notes: lag stalls each ack; the idle input bus toggles so a stale byte never looks valid
`timescale 1ns/100ps
module dma_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] lag,
  // input channel
  input wire logic dma_in_req,
  output logic dma_in_ack,
  output logic [7:0] dma_in_data,
  // output channel
  input wire logic dma_out_req,
  output logic dma_out_ack,
  input wire logic [7:0] dma_out_data
);
  logic [7:0] src_q [$];
  logic [7:0] sink_q [$];
  logic [3:0] in_wait_r;
  logic [3:0] out_wait_r;
  initial begin
    dma_in_ack = 1'b0;
    dma_in_data = 8'h00;
    dma_out_ack = 1'b0;
  end
  // memory to codec, bytes leave in memory order, big-endian
  always @(posedge core_clk) begin
    dma_in_ack <= 1'b0;
    dma_in_data <= ~dma_in_data;
    if (!rst_b || !dma_in_req) begin
      in_wait_r <= 4'h0;
    end else if (!dma_in_ack && in_wait_r >= lag && src_q.size() > 0) begin
      dma_in_ack <= 1'b1;
      dma_in_data <= src_q.pop_front();
      in_wait_r <= 4'h0;
    end else if (!dma_in_ack) begin
      in_wait_r <= in_wait_r + 4'h1;
    end
  end
  // codec to memory, one ack per byte, no ack while the last one is in flight
  always @(posedge core_clk) begin
    dma_out_ack <= 1'b0;
    if (!rst_b || !dma_out_req) begin
      out_wait_r <= 4'h0;
    end else if (!dma_out_ack && out_wait_r >= lag) begin
      dma_out_ack <= 1'b1;
      sink_q.push_back(dma_out_data);
      out_wait_r <= 4'h0;
    end else if (!dma_out_ack) begin
      out_wait_r <= out_wait_r + 4'h1;
    end
  end
endmodule : dma_mem_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the symbol codec, register and dma paths
// Assumes: register read data is sampled 1 ns after the edge ending the strobe cycle
// Notes: clk_en stays high except for one frozen register write near the end
`timescale 1ns/100ps
`include "codec_map.svh"
module tb_top;
  typedef struct packed {
    logic [7:0] ctl, h, m, l, eh, em, el;
    logic [2:0] msk;
    logic err;
  } row_t;
  logic core_clk, rst_b, clk_en, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, dma_in_data, dma_out_data;
  logic dma_in_req, dma_in_ack, dma_out_req, dma_out_ack, decode_err_irq, ready_flag;
  logic [3:0] lag;
  int fails = 0;
  int check_count = 0;
  // msk picks high, middle, low; manchester leaves bytes outside its result unchecked
  row_t rows [9] = '{
    '{8'h21, 8'h00, 8'h01, 8'h23, 8'h58, 8'hd3, 8'h8b, 3'h7, 1'b0},
    '{8'h21, 8'h00, 8'hff, 8'h80, 8'ha6, 8'h9b, 8'h16, 3'h7, 1'b0},
    '{8'h11, 8'h58, 8'hd3, 8'h8b, 8'h00, 8'h01, 8'h23, 3'h7, 1'b0},
    '{8'h11, 8'ha6, 8'h9b, 8'h16, 8'h00, 8'hff, 8'h80, 3'h7, 1'b0},
    '{8'h11, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 3'h7, 1'b1},
    '{8'h11, 8'h58, 8'hd3, 8'h8f, 8'hff, 8'hff, 8'hff, 3'h7, 1'b1},
    '{8'h20, 8'h00, 8'h00, 8'h5a, 8'h00, 8'h99, 8'h66, 3'h3, 1'b0},
    '{8'h10, 8'h00, 8'h99, 8'h66, 8'h00, 8'h00, 8'h5a, 3'h1, 1'b0},
    '{8'h10, 8'h00, 8'h00, 8'h55, 8'hff, 8'hff, 8'hff, 3'h7, 1'b1}
  };
  symbol_codec i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dma_in_req(dma_in_req), .dma_in_ack(dma_in_ack), .dma_in_data(dma_in_data),
    .dma_out_req(dma_out_req), .dma_out_ack(dma_out_ack), .dma_out_data(dma_out_data),
    .decode_err_irq(decode_err_irq), .ready_flag(ready_flag)
  );
  dma_mem_model i_mem (
    .core_clk(core_clk), .rst_b(rst_b), .lag(lag),
    .dma_in_req(dma_in_req), .dma_in_ack(dma_in_ack), .dma_in_data(dma_in_data),
    .dma_out_req(dma_out_req), .dma_out_ack(dma_out_ack), .dma_out_data(dma_out_data)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // data launched at this edge stand for one cycle only; take them once settled
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic wait_ready();
    logic [7:0] c;
    for (int i = 0; i < 40; i++) begin
      rd(`CODEC_OFS_CONTROL, c);
      if (c[`CODEC_BIT_READY] === 1'b1) return;
    end
    fails++;
    tally_and_finish();
  endtask : wait_ready
  // one dma run over one or more blocks; the stop write comes only after the error flag is looked at
  task automatic dma_run(input logic [7:0] c, input logic [7:0] src[$],
                         input logic [7:0] dx[$], input logic err);
    logic [7:0] v;
    wr(`CODEC_OFS_CONTROL, 8'h00);
    i_mem.sink_q.delete();
    i_mem.src_q = src;
    wr(`CODEC_OFS_CONTROL, c);
    for (int i = 0; i < 300 && i_mem.sink_q.size() < dx.size(); i++) @(posedge core_clk);
    if (i_mem.sink_q.size() < dx.size()) begin
      $display("MISMATCH at %0t: dma output timed out", $time);
      fails++;
      tally_and_finish();
    end
    foreach (dx[k]) chk(i_mem.sink_q[k], dx[k]);
    rd(`CODEC_OFS_CONTROL, v);
    chk({7'h00, v[`CODEC_BIT_ERROR]}, {7'h00, err});
    chk({7'h00, decode_err_irq}, {7'h00, err});
    wr(`CODEC_OFS_CONTROL, 8'h00);
  endtask : dma_run
  initial begin
    logic [7:0] v;
    logic [7:0] ec;
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lag = 4'h0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    // four registers reset to zero; offset 4 is unmapped and reads zero
    for (int a = 0; a < 5; a++) begin
      rd(8'(a), v);
      chk(v, 8'h00);
    end
    foreach (rows[i]) begin
      wr(`CODEC_OFS_CONTROL, 8'h00);
      wr(`CODEC_OFS_HIGH, rows[i].h);
      wr(`CODEC_OFS_MIDDLE, rows[i].m);
      wr(`CODEC_OFS_LOW, rows[i].l);
      wr(`CODEC_OFS_CONTROL, rows[i].ctl);
      wait_ready();
      ec = 8'h80 | {1'b0, rows[i].err, 6'h00} | (rows[i].ctl & 8'h07);
      rd(`CODEC_OFS_CONTROL, v);
      chk(v, ec);
      chk({7'h00, decode_err_irq}, {7'h00, rows[i].err});
      chk({7'h00, ready_flag}, 8'h01);
      rd(`CODEC_OFS_HIGH, v);
      if (rows[i].msk[2]) chk(v, rows[i].eh);
      rd(`CODEC_OFS_MIDDLE, v);
      if (rows[i].msk[1]) chk(v, rows[i].em);
      rd(`CODEC_OFS_LOW, v);
      if (rows[i].msk[0]) chk(v, rows[i].el);
      repeat (5) @(posedge core_clk);
      rd(`CODEC_OFS_CONTROL, v);
      chk(v, ec);
    end
    wr(`CODEC_OFS_CONTROL, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({6'h00, ready_flag, decode_err_irq}, 8'h00);
    dma_run(8'h27, '{8'h01, 8'h23}, '{8'h58, 8'hd3, 8'h8b}, 1'b0);
    dma_run(8'h26, '{8'h5a}, '{8'h99, 8'h66}, 1'b0);
    lag <= 4'h3;
    // a bad block first, then a good one: decoding goes on and the error stays
    dma_run(8'h17, '{8'h00, 8'h00, 8'h00, 8'h58, 8'hd3, 8'h8b},
            '{8'hff, 8'hff, 8'h01, 8'h23}, 1'b1);
    dma_run(8'h16, '{8'h99, 8'h66}, '{8'h5a}, 1'b0);
    // a write while frozen must not land
    wr(`CODEC_OFS_LOW, 8'h3c);
    clk_en <= 1'b0;
    wr(`CODEC_OFS_LOW, 8'hc3);
    clk_en <= 1'b1;
    rd(`CODEC_OFS_LOW, v);
    chk(v, 8'h3c);
    // reset in mid-run clears the data registers again
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`CODEC_OFS_LOW, v);
    chk(v, 8'h00);
    rd(`CODEC_OFS_CONTROL, v);
    chk(v, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
